// *** hw/dcap_banks.sv ***
`timescale 1ns/10ps
// Open/idle state and open row of each bank
module dcap_banks (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic sysEn,
  input wire logic actEn,
  input wire logic preEn,
  input wire logic preAll,
  input wire logic [dcap_pkg::BANK_BITS-1:0] bankSel,
  input wire logic [dcap_pkg::ROW_BITS-1:0] rowIn,
  input wire logic apEn,
  input wire logic [dcap_pkg::BANK_BITS-1:0] apBank,
  output logic [dcap_pkg::BANKS-1:0] bankOpen,
  output logic [dcap_pkg::BANKS-1:0][dcap_pkg::ROW_BITS-1:0] openRow
);
  for (genvar b = 0; b < dcap_pkg::BANKS; b++) begin : gBank
    localparam logic [dcap_pkg::BANK_BITS-1:0] ID = dcap_pkg::BANK_BITS'(b);
    always_ff @(posedge sys_clk) begin
      if (reset) begin
        bankOpen[b] <= 1'b0;
        openRow[b] <= '0;
      end else if (sysEn) begin
        if (actEn && bankSel == ID) begin
          bankOpen[b] <= 1'b1;
          openRow[b] <= rowIn;
        end else if ((preEn && (preAll || bankSel == ID)) || (apEn && apBank == ID)) begin
          bankOpen[b] <= 1'b0;
        end
      end
    end
  end
endmodule

// *** hw/dcap_pkg.sv ***
package dcap_pkg;
  // Array organization: 8 banks x 32 Mbit per data line x 16 lines
  localparam int BANKS = 8;
  localparam int BANK_BITS = 3;
  localparam int ROW_BITS = 15;
  localparam int COL_BITS = 10;
  localparam int DQ_BITS = 16;
  localparam int DM_BITS = 2;
  localparam int BYTE_BITS = 8;
  localparam int MR_COUNT = 4;
  localparam int MR_SEL_BITS = 2;
  localparam int AP_BIT = 10;
  localparam int BC_BIT = 12;
  // Flop storage window, indexed by bank, row bit 0 and column bits 2..0
  localparam int MEM_WORDS = 128;
  localparam int MEM_IDX_BITS = 7;
  localparam int BURST_COL_BITS = 3;
  localparam int MR0_BL_LSB = 0;
  localparam int MR0_BL_W = 2;
  localparam int MR0_BT_BIT = 3;
  localparam int MR0_CL_LSB = 4;
  localparam int MR0_CL_W = 3;
  localparam int MR1_AL_LSB = 3;
  localparam int MR1_AL_W = 2;
  localparam logic [1:0] BL_FIXED8 = 2'h0;
  localparam logic [1:0] BL_OTF = 2'h1;
  localparam logic [1:0] BL_CHOP4 = 2'h2;
  localparam logic [1:0] AL_ZERO = 2'h0;
  localparam logic [1:0] AL_CL1 = 2'h1;
  localparam logic [1:0] AL_CL2 = 2'h2;
  localparam logic [4:0] CL_BASE = 5'h05;
  localparam logic [3:0] BEATS_FULL = 4'h8;
  localparam logic [3:0] BEATS_CHOP = 4'h4;
  localparam logic [14:0] MR_RESET = 15'h0000;
  localparam int SYNC_W = 44;

  typedef struct packed {
    logic csN;
    logic rasN;
    logic casN;
    logic weN;
    logic [BANK_BITS-1:0] ba;
    logic [ROW_BITS-1:0] addr;
  } dcap_cmd_s;

  typedef enum logic [2:0] {OP_NOP, OP_MRS, OP_REF, OP_PRE, OP_ACT, OP_WR, OP_RD} dcap_op_e;
  typedef enum logic [1:0] {PWR_ACTIVE, PWR_PD_PRE, PWR_PD_ACT, PWR_SELF_REF} dcap_pwr_e;
  typedef enum logic [1:0] {D_IDLE, D_RDWAIT, D_RDBURST, D_WRBURST} dcap_data_e;
endpackage

// *** hw/dcap_port.sv ***
`timescale 1ns/10ps
// Notes on behaviour
// - Commands and address are taken where true clock rises and complement falls.
// - Read data and strobe change on both clock crossings, two beats per period.
// - Clock enable sampled low suspends internal clock; burst and outputs stay frozen.
// - Clock enable low enters power-down or self-refresh; open banks stay open in active power-down.
// - Three bank bits pick the bank for activate, read, write and precharge.
// - Activate takes the full fifteen-bit row address.
// - Read and write take a three-bit column from the low address bits.
// - Address bit ten high on read or write precharges the bank afterwards.
// - Precharge with bit ten low closes one bank; high closes all banks.
// - In on-the-fly burst mode, address bit twelve low chops the burst to four; high keeps it full.
// - Mode register set loads the address op-code into the addressed mode register.
// - Burst length is programmable as four or eight beats.
// - Burst column order is sequential or interleaved by programming.
// - Additive latency is zero, CL minus one or CL minus two.
// - Eight banks open and close independently; only one read or write burst runs at a time.
// - Array is 32 Mbit per data line, sixteen lines, eight banks.
// - Write data is taken on the data strobe, not on the command clock; read data follows the clock crossings.
// - Chip select high masks every command.
// - Row strobe low, column strobe high: write-enable high activates, low precharges.
// - Column strobe low, row strobe high: write-enable high reads, low writes.
// - Data mask high discards the matching write byte.
module dcap_port (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic sysEn,
  input wire logic ckPin,
  input wire logic ckNPin,
  input wire logic ckePin,
  input wire dcap_pkg::dcap_cmd_s cmdPin,
  input wire logic dqsPin,
  input wire logic [dcap_pkg::DM_BITS-1:0] dmPin,
  input wire logic [dcap_pkg::DQ_BITS-1:0] dqPin,
  output logic [dcap_pkg::DQ_BITS-1:0] dqOut,
  output logic dqOe,
  output logic dqsOut,
  output logic dqsNOut,
  output logic dqsOe,
  output logic [dcap_pkg::BANKS-1:0] bankOpen,
  output dcap_pkg::dcap_pwr_e powerState
);
  logic [dcap_pkg::SYNC_W-1:0] pinSync;
  logic ckS, ckNS, ckeS;
  dcap_pkg::dcap_cmd_s cmdS;
  logic dqsS;
  logic [dcap_pkg::DM_BITS-1:0] dmS;
  logic [dcap_pkg::DQ_BITS-1:0] dqS;
  logic ckPrev, ckCross, ckRise, ckFall, ckRun;
  logic dqsPrev;
  logic dqsEdge;
  logic take;
  dcap_pkg::dcap_op_e op;
  logic [dcap_pkg::MR_COUNT-1:0][dcap_pkg::ROW_BITS-1:0] modeReg;
  logic [dcap_pkg::BANKS-1:0][dcap_pkg::ROW_BITS-1:0] openRow;
  logic allIdle;
  dcap_pkg::dcap_data_e dataState;
  logic [4:0] rdWait;
  logic [3:0] beat;
  logic [3:0] burstLen;
  logic [dcap_pkg::BANK_BITS-1:0] burstBank;
  logic burstRow0;
  logic [dcap_pkg::BURST_COL_BITS-1:0] burstCol;
  logic burstAp, burstIl, apPulse;
  logic [4:0] clNow;
  logic [4:0] readLat;
  logic [1:0] blField;
  logic startBurst, beatNow, rdEnd, wrNow;
  logic [dcap_pkg::MEM_IDX_BITS-1:0] beatIdx;
  logic [dcap_pkg::DQ_BITS-1:0] mem [dcap_pkg::MEM_WORDS];

  function automatic logic [2:0] beatCol(input logic [2:0] start, input logic [2:0] i,
                                         input logic il);
    beatCol = il ? (start ^ i) : {start[2] ^ i[2], 2'(start[1:0] + i[1:0])};
  endfunction

  function automatic logic [dcap_pkg::MEM_IDX_BITS-1:0] memIdx(
      input logic [dcap_pkg::BANK_BITS-1:0] bank, input logic row0, input logic [2:0] col);
    memIdx = {bank, row0, col};
  endfunction

  dcap_sync #(.W(dcap_pkg::SYNC_W)) uSync (
    .sys_clk(sys_clk),
    .reset(reset),
    .sysEn(sysEn),
    .pinIn({ckPin, ckNPin, ckePin, cmdPin, dqsPin, dmPin, dqPin}),
    .pinSync(pinSync)
  );

  assign {ckS, ckNS, ckeS, cmdS, dqsS, dmS, dqS} = pinSync;

  // Crossing of the differential clock pair
  assign ckCross = ckS & ~ckNS;
  assign ckRise = ckCross & ~ckPrev;
  assign ckFall = ~ckCross & ckPrev;
  assign dqsEdge = dqsS ^ dqsPrev;
  assign take = ckRise & ckRun;

  always_comb begin
    op = dcap_pkg::OP_NOP;
    if (!cmdS.csN) begin
      case ({cmdS.rasN, cmdS.casN, cmdS.weN})
        3'h0: op = dcap_pkg::OP_MRS;
        3'h1: op = dcap_pkg::OP_REF;
        3'h2: op = dcap_pkg::OP_PRE;
        3'h3: op = dcap_pkg::OP_ACT;
        3'h4: op = dcap_pkg::OP_WR;
        3'h5: op = dcap_pkg::OP_RD;
        default: op = dcap_pkg::OP_NOP;
      endcase
    end
  end

  assign clNow = 5'(dcap_pkg::CL_BASE + 5'(modeReg[0][dcap_pkg::MR0_CL_LSB +: dcap_pkg::MR0_CL_W]));

  always_comb begin
    case (modeReg[1][dcap_pkg::MR1_AL_LSB +: dcap_pkg::MR1_AL_W])
      dcap_pkg::AL_CL1: readLat = 5'(clNow + clNow - 5'h01);
      dcap_pkg::AL_CL2: readLat = 5'(clNow + clNow - 5'h02);
      default: readLat = clNow;
    endcase
  end

  assign blField = modeReg[0][dcap_pkg::MR0_BL_LSB +: dcap_pkg::MR0_BL_W];
  assign startBurst = take && dataState == dcap_pkg::D_IDLE && bankOpen[cmdS.ba]
                      && (op == dcap_pkg::OP_RD || op == dcap_pkg::OP_WR);
  assign beatNow = ckRun && ((dataState == dcap_pkg::D_RDWAIT && ckRise && rdWait == 5'h01)
                   || (dataState == dcap_pkg::D_RDBURST && (ckRise || ckFall)
                   && beat != burstLen));
  assign rdEnd = ckRun && dataState == dcap_pkg::D_RDBURST && (ckRise || ckFall)
                 && beat == burstLen;
  assign wrNow = ckRun && dataState == dcap_pkg::D_WRBURST && dqsEdge;
  assign beatIdx = memIdx(burstBank, burstRow0, beatCol(burstCol, beat[2:0], burstIl));
  assign allIdle = ~|bankOpen;

  dcap_banks uBanks (
    .sys_clk(sys_clk),
    .reset(reset),
    .sysEn(sysEn),
    .actEn(take && op == dcap_pkg::OP_ACT),
    .preEn(take && op == dcap_pkg::OP_PRE),
    .preAll(cmdS.addr[dcap_pkg::AP_BIT]),
    .bankSel(cmdS.ba),
    .rowIn(cmdS.addr),
    .apEn(apPulse),
    .apBank(burstBank),
    .bankOpen(bankOpen),
    .openRow(openRow)
  );

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ckPrev <= 1'b0;
      dqsPrev <= 1'b0;
    end else if (sysEn) begin
      ckPrev <= ckCross;
      dqsPrev <= dqsS;
    end
  end

  // Internal clock runs on the cycle after a high clock enable sample
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ckRun <= 1'b1;
    end else if (sysEn && ckRise) begin
      ckRun <= ckeS;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      powerState <= dcap_pkg::PWR_ACTIVE;
    end else if (sysEn && ckRise) begin
      if (ckRun && !ckeS) begin
        if (op == dcap_pkg::OP_REF && allIdle) begin
          powerState <= dcap_pkg::PWR_SELF_REF;
        end else if (allIdle) begin
          powerState <= dcap_pkg::PWR_PD_PRE;
        end else begin
          powerState <= dcap_pkg::PWR_PD_ACT;
        end
      end else if (!ckRun && ckeS) begin
        powerState <= dcap_pkg::PWR_ACTIVE;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      modeReg <= {dcap_pkg::MR_COUNT{dcap_pkg::MR_RESET}};
    end else if (sysEn && take && op == dcap_pkg::OP_MRS) begin
      modeReg[cmdS.ba[dcap_pkg::MR_SEL_BITS-1:0]] <= cmdS.addr;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      dataState <= dcap_pkg::D_IDLE;
      rdWait <= 5'h00;
      beat <= 4'h0;
      burstLen <= dcap_pkg::BEATS_FULL;
      burstBank <= '0;
      burstRow0 <= 1'b0;
      burstCol <= '0;
      burstAp <= 1'b0;
      burstIl <= 1'b0;
      apPulse <= 1'b0;
    end else if (sysEn) begin
      apPulse <= 1'b0;
      case (dataState)
        dcap_pkg::D_IDLE: begin
          if (startBurst) begin
            burstBank <= cmdS.ba;
            burstRow0 <= openRow[cmdS.ba][0];
            burstCol <= cmdS.addr[dcap_pkg::BURST_COL_BITS-1:0];
            burstAp <= cmdS.addr[dcap_pkg::AP_BIT];
            burstIl <= modeReg[0][dcap_pkg::MR0_BT_BIT];
            if (blField == dcap_pkg::BL_CHOP4 || (blField == dcap_pkg::BL_OTF
                && !cmdS.addr[dcap_pkg::BC_BIT])) begin
              burstLen <= dcap_pkg::BEATS_CHOP;
            end else begin
              burstLen <= dcap_pkg::BEATS_FULL;
            end
            beat <= 4'h0;
            rdWait <= readLat;
            dataState <= (op == dcap_pkg::OP_RD) ? dcap_pkg::D_RDWAIT : dcap_pkg::D_WRBURST;
          end
        end
        dcap_pkg::D_RDWAIT: begin
          if (beatNow) begin
            beat <= 4'h1;
            dataState <= dcap_pkg::D_RDBURST;
          end else if (take) begin
            rdWait <= 5'(rdWait - 5'h01);
          end
        end
        dcap_pkg::D_RDBURST: begin
          if (beatNow) begin
            beat <= 4'(beat + 4'h1);
          end else if (rdEnd) begin
            apPulse <= burstAp;
            dataState <= dcap_pkg::D_IDLE;
          end
        end
        dcap_pkg::D_WRBURST: begin
          if (wrNow) begin
            beat <= 4'(beat + 4'h1);
            if (beat == 4'(burstLen - 4'h1)) begin
              apPulse <= burstAp;
              dataState <= dcap_pkg::D_IDLE;
            end
          end
        end
        default: dataState <= dcap_pkg::D_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      dqOut <= '0;
      dqOe <= 1'b0;
      dqsOut <= 1'b0;
      dqsNOut <= 1'b1;
      dqsOe <= 1'b0;
    end else if (sysEn) begin
      if (beatNow) begin
        dqOut <= mem[beatIdx];
        dqOe <= 1'b1;
        dqsOut <= ckRise;
        dqsNOut <= ~ckRise;
        dqsOe <= 1'b1;
      end else if (rdEnd) begin
        dqOe <= 1'b0;
        dqsOut <= 1'b0;
        dqsNOut <= 1'b1;
        dqsOe <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sysEn && wrNow) begin
      for (int b = 0; b < dcap_pkg::DM_BITS; b++) begin
        if (!dmS[b]) begin
          mem[beatIdx][b*dcap_pkg::BYTE_BITS +: dcap_pkg::BYTE_BITS] <=
            dqS[b*dcap_pkg::BYTE_BITS +: dcap_pkg::BYTE_BITS];
        end
      end
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset || !sysEn);

  AST_CS_IGNORE: assert property (
    ckRise && ckRun && cmdS.csN && !apPulse |=> bankOpen == $past(bankOpen)
  ) else $error("Command taken with chip select high");
  AST_ACT_OPENS: assert property (
    take && op == dcap_pkg::OP_ACT
    |=> bankOpen[$past(cmdS.ba)] && openRow[$past(cmdS.ba)] == $past(cmdS.addr)
  ) else $error("Activate did not open bank with row");
  AST_PRE_ALL: assert property (
    take && op == dcap_pkg::OP_PRE && cmdS.addr[dcap_pkg::AP_BIT] |=> bankOpen == '0
  ) else $error("Precharge all left a bank open");
  AST_MRS_LOAD: assert property (
    take && op == dcap_pkg::OP_MRS
    |=> modeReg[$past(cmdS.ba[dcap_pkg::MR_SEL_BITS-1:0])] == $past(cmdS.addr)
  ) else $error("Mode register not loaded");
  AST_FREEZE: assert property (
    !ckRun |=> $stable(beat) && $stable(dqOut) && $stable(dqsOut)
  ) else $error("Burst advanced while clock suspended");
  AST_DQS_FALL: assert property (
    dataState == dcap_pkg::D_RDBURST && ckFall && ckRun && beat != burstLen
    |=> !dqsOut && dqsNOut && dqOe ##1 dqOe
  ) else $error("Falling crossing beat not driven");
  AST_RD_LAT: assert property (
    startBurst && op == dcap_pkg::OP_RD |=> rdWait == $past(readLat)
      && dataState == dcap_pkg::D_RDWAIT
  ) else $error("Read latency not loaded");
  AST_PD_ENTRY: assert property (
    ckRise && ckRun && !ckeS && op != dcap_pkg::OP_REF && allIdle
    |=> powerState == dcap_pkg::PWR_PD_PRE
  ) else $error("Idle power-down not entered");
  AST_CHOP: assert property (
    startBurst && blField == dcap_pkg::BL_OTF && !cmdS.addr[dcap_pkg::BC_BIT]
    |=> burstLen == dcap_pkg::BEATS_CHOP
  ) else $error("Chopped burst not selected");
  AST_AP_CLOSE: assert property (
    apPulse |=> !bankOpen[$past(burstBank)]
  ) else $error("Auto-precharge left bank open");
endmodule

// *** hw/dcap_sync.sv ***
`timescale 1ns/10ps
// Two-flop synchroniser for a group of pins
module dcap_sync #(
  parameter int W = 1
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic sysEn,
  input wire logic [W-1:0] pinIn,
  output logic [W-1:0] pinSync
);
  logic [W-1:0] stage1;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      stage1 <= '0;
      pinSync <= '0;
    end else if (sysEn) begin
      stage1 <= pinIn;
      pinSync <= stage1;
    end
  end
endmodule

// *** testbench/dcap_ctrl_model.sv ***
`timescale 1ns/10ps
// Controller side of the link: free-running clock, commands and write bursts
module dcap_ctrl_model (
  input wire logic sys_clk,
  output logic ckPin,
  output logic ckNPin,
  output logic ckePin,
  output dcap_pkg::dcap_cmd_s cmdPin,
  output logic dqsPin,
  output logic [1:0] dmPin,
  output logic [15:0] dqPin
);
  initial begin
    ckPin = 1'b0;
    ckePin = 1'b1;
    cmdPin = {4'hf, 3'h0, 15'h0000};
    dqsPin = 1'b0;
    dmPin = 2'h0;
    dqPin = 16'h0000;
    #7;
    forever #160 ckPin = ~ckPin;
  end
  assign ckNPin = ~ckPin;

  // Changes land mid-cycle so the pins are settled at the rising crossing
  task automatic issue(input logic cs, input logic cke, input logic [2:0] rcw,
      input logic [2:0] ba, input logic [14:0] addr);
    @(negedge ckPin);
    @(negedge sys_clk);
    ckePin = cke;
    cmdPin = {cs, rcw, ba, addr};
    @(negedge ckPin);
    @(negedge sys_clk);
    cmdPin = {1'b1, 3'h7, ~ba, ~addr};
  endtask

  task automatic write_burst(input logic [2:0] ba, input logic [14:0] addr,
      input logic [7:0][15:0] dat, input logic [7:0][1:0] dm, input int n);
    issue(1'b0, 1'b1, 3'h4, ba, addr);
    for (int k = 0; k < n; k++) begin
      repeat (3) @(negedge sys_clk);
      dqPin = dat[k];
      dmPin = dm[k];
      repeat (3) @(negedge sys_clk);
      dqsPin = ~dqsPin;
    end
    repeat (3) @(negedge sys_clk);
    dqPin = ~dqPin;
    dmPin = ~dmPin;
  endtask
endmodule

// *** testbench/dcap_port_tb.sv ***
`timescale 1ns/10ps
module dcap_port_tb;
  logic sys_clk;
  logic reset;
  logic sysEn;
  logic ckPin, ckNPin, ckePin, dqsPin, dqOe, dqsOut, dqsNOut, dqsOe;
  dcap_pkg::dcap_cmd_s cmdPin;
  logic [1:0] dmPin;
  logic [15:0] dqPin, dqOut;
  logic [7:0] bankOpen;
  dcap_pkg::dcap_pwr_e powerState;
  logic [15:0] expMem [128];
  logic [7:0] rowBit;
  int nFail = 0;
  int nCompared = 0;

  dcap_port i_dcap_port (
    .sys_clk(sys_clk), .reset(reset), .sysEn(sysEn), .ckPin(ckPin), .ckNPin(ckNPin),
    .ckePin(ckePin), .cmdPin(cmdPin), .dqsPin(dqsPin), .dmPin(dmPin), .dqPin(dqPin),
    .dqOut(dqOut), .dqOe(dqOe), .dqsOut(dqsOut), .dqsNOut(dqsNOut), .dqsOe(dqsOe),
    .bankOpen(bankOpen), .powerState(powerState)
  );

  dcap_ctrl_model i_dcap_ctrl_model (
    .sys_clk(sys_clk), .ckPin(ckPin), .ckNPin(ckNPin), .ckePin(ckePin),
    .cmdPin(cmdPin), .dqsPin(dqsPin), .dmPin(dmPin), .dqPin(dqPin)
  );

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    nCompared++;
    if (got !== exp) begin
      nFail++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic summarize;
    $display("compared %0d, mismatches %0d", nCompared, nFail);
    if (nFail == 0 && nCompared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  function automatic logic [2:0] bcol(input logic [2:0] c, input logic [2:0] i,
      input logic il);
    return il ? (c ^ i) : {c[2] ^ i[2], c[1:0] + i[1:0]};
  endfunction

  task automatic cmd(input logic cs, input logic cke, input logic [2:0] rcw,
      input logic [2:0] ba, input logic [14:0] addr);
    i_dcap_ctrl_model.issue(cs, cke, rcw, ba, addr);
    repeat (3) @(negedge sys_clk);
  endtask

  task automatic settle;
    @(posedge ckPin);
    repeat (6) @(negedge sys_clk);
  endtask

  task automatic wr(input logic [2:0] ba, input logic [14:0] addr, input logic [15:0] base,
      input logic [7:0][1:0] dm);
    logic [7:0][15:0] dat;
    logic [6:0] ix;
    for (int k = 0; k < 8; k++) begin
      dat[k] = base + 16'(k);
      ix = {ba, rowBit[ba], bcol(addr[2:0], 3'(k), 1'b0)};
      if (!dm[k][0]) expMem[ix][7:0] = dat[k][7:0];
      if (!dm[k][1]) expMem[ix][15:8] = dat[k][15:8];
    end
    i_dcap_ctrl_model.write_burst(ba, addr, dat, dm, 8);
    repeat (4) @(negedge sys_clk);
  endtask

  task automatic rd(input logic [2:0] ba, input logic [14:0] addr, input int rl,
      input int n, input logic il);
    logic [6:0] ix;
    i_dcap_ctrl_model.issue(1'b0, 1'b1, 3'h5, ba, addr);
    repeat (rl) @(posedge ckPin);
    chk({15'h0000, dqOe}, 16'h0000, "early data");
    for (int i = 0; i < n; i++) begin
      @(ckPin);
      ix = {ba, rowBit[ba], bcol(addr[2:0], 3'(i), il)};
      chk(dqOut, expMem[ix], "read beat");
      chk({12'h000, dqOe, dqsOe, dqsOut, dqsNOut}, {12'h000, 2'h3, ~i[0], i[0]}, "strobe");
    end
    @(ckPin);
    chk({14'h0000, dqOe, dqsOe}, 16'h0000, "burst end");
  endtask

  task automatic t_reset;
    reset = 1'b1;
    sysEn = 1'b1;
    repeat (5) @(negedge sys_clk);
    reset = 1'b0;
    repeat (4) @(negedge sys_clk);
    chk({4'h0, dqOe, dqsOut, dqsNOut, dqsOe, bankOpen}, 16'h0200, "reset pins");
    chk(16'(powerState), 16'(dcap_pkg::PWR_ACTIVE), "reset power");
  endtask

  task automatic t_decode;
    cmd(1'b0, 1'b1, 3'h0, 3'h0, 15'h0000);
    cmd(1'b0, 1'b1, 3'h0, 3'h1, 15'h0000);
    cmd(1'b1, 1'b1, 3'h3, 3'h2, 15'h0000);
    chk({8'h00, bankOpen}, 16'h0000, "deselected act");
    cmd(1'b0, 1'b1, 3'h3, 3'h3, 15'h0001);
    rowBit[3] = 1'b1;
    cmd(1'b0, 1'b1, 3'h3, 3'h5, 15'h7ffe);
    rowBit[5] = 1'b0;
    chk({8'h00, bankOpen}, 16'h0028, "activate");
  endtask

  task automatic t_write_read;
    wr(3'h3, 15'h0000, 16'ha000, 16'h0000);
    wr(3'h3, 15'h0000, 16'hb000, 16'he4e4);
    rd(3'h3, 15'h0002, 5, 8, 1'b0);
    chk({8'h00, bankOpen}, 16'h0028, "no auto precharge");
  endtask

  task automatic t_chop;
    cmd(1'b0, 1'b1, 3'h0, 3'h0, 15'h0009);
    cmd(1'b0, 1'b1, 3'h0, 3'h1, 15'h0008);
    rd(3'h3, 15'h0405, 9, 4, 1'b1);
    settle;
    chk({8'h00, bankOpen}, 16'h0020, "auto precharge");
  endtask

  task automatic t_fixed_chop;
    cmd(1'b0, 1'b1, 3'h0, 3'h0, 15'h0002);
    cmd(1'b0, 1'b1, 3'h0, 3'h1, 15'h0010);
    cmd(1'b0, 1'b1, 3'h3, 3'h3, 15'h0001);
    rd(3'h3, 15'h1001, 8, 4, 1'b0);
    cmd(1'b0, 1'b1, 3'h2, 3'h3, 15'h0000);
    chk({8'h00, bankOpen}, 16'h0020, "precharge bank");
  endtask

  task automatic t_pre;
    cmd(1'b0, 1'b1, 3'h3, 3'h0, 15'h0000);
    cmd(1'b0, 1'b1, 3'h2, 3'h5, 15'h0000);
    chk({8'h00, bankOpen}, 16'h0001, "precharge one");
    cmd(1'b0, 1'b1, 3'h3, 3'h1, 15'h0000);
    cmd(1'b0, 1'b1, 3'h2, 3'h7, 15'h0400);
    chk({8'h00, bankOpen}, 16'h0000, "precharge all");
    cmd(1'b0, 1'b1, 3'h1, 3'h0, 15'h0000);
    chk({8'h00, bankOpen}, 16'h0000, "refresh");
  endtask

  task automatic t_power;
    cmd(1'b0, 1'b1, 3'h3, 3'h0, 15'h0000);
    cmd(1'b1, 1'b0, 3'h7, 3'h0, 15'h0000);
    settle;
    chk(16'(powerState), 16'(dcap_pkg::PWR_PD_ACT), "active power-down");
    cmd(1'b0, 1'b0, 3'h3, 3'h1, 15'h0000);
    chk({8'h00, bankOpen}, 16'h0001, "frozen act");
    cmd(1'b1, 1'b1, 3'h7, 3'h0, 15'h0000);
    settle;
    chk(16'(powerState), 16'(dcap_pkg::PWR_ACTIVE), "exit");
    cmd(1'b0, 1'b1, 3'h2, 3'h0, 15'h0400);
    cmd(1'b1, 1'b0, 3'h7, 3'h0, 15'h0000);
    settle;
    chk(16'(powerState), 16'(dcap_pkg::PWR_PD_PRE), "idle power-down");
    cmd(1'b1, 1'b1, 3'h7, 3'h0, 15'h0000);
    settle;
    cmd(1'b0, 1'b0, 3'h1, 3'h0, 15'h0000);
    settle;
    chk(16'(powerState), 16'(dcap_pkg::PWR_SELF_REF), "self refresh");
    cmd(1'b1, 1'b1, 3'h7, 3'h0, 15'h0000);
    settle;
    chk(16'(powerState), 16'(dcap_pkg::PWR_ACTIVE), "exit");
  endtask

  task automatic t_hold;
    sysEn = 1'b0;
    cmd(1'b0, 1'b1, 3'h3, 3'h6, 15'h0000);
    chk({8'h00, bankOpen}, 16'h0000, "frozen enable");
    sysEn = 1'b1;
    settle;
    chk({8'h00, bankOpen}, 16'h0000, "no late act");
  endtask

  initial begin
    repeat (60000) @(posedge sys_clk);
    nFail++;
    $display("mismatch at %0t: run did not end", $time);
    summarize;
  end

  initial begin
    t_reset;
    t_decode;
    t_write_read;
    t_chop;
    t_fixed_chop;
    t_pre;
    t_power;
    t_hold;
    summarize;
  end
endmodule
